// file: verilog/ppr_pkg.sv
// Constants and types for the process regulator.
package ppr_pkg;
   // ****************************************
   // Scaling
   // ****************************************
   localparam logic [15:0] PCT_FULL = 16'h2710;
   localparam logic [15:0] GAIN_UNITY = 16'h03e8;
   localparam int SAMPLE_PERIOD_US = 10000;
   localparam int CLK_FREQ_MHZ = 200;
   localparam int SAMPLE_CYCLES_DEFAULT = SAMPLE_PERIOD_US * CLK_FREQ_MHZ;
   localparam int TI_UNIT_US = 100000;
   localparam int TD_UNIT_US = 100;
   localparam logic [15:0] TI_SAMPLES_PER_UNIT = 16'(TI_UNIT_US / SAMPLE_PERIOD_US);
   localparam logic [15:0] TD_DIVISOR = 16'(SAMPLE_PERIOD_US / TD_UNIT_US);
   localparam logic signed [63:0] U_LIMIT = 64'sh0000_0000_0001_86a0;
   // ****************************************
   // Parameter defaults
   // ****************************************
   localparam logic [15:0] KP_DEFAULT = 16'h000a;
   localparam logic [15:0] TI_DEFAULT = 16'h0064;
   localparam logic [15:0] TD_DEFAULT = 16'h0000;
   localparam logic [15:0] UPPER_DEFAULT = 16'h1770;
   localparam logic [15:0] SCALE_DEFAULT = 16'h03e8;
   localparam logic [15:0] FF_DEFAULT = 16'h0000;
   // ****************************************
   // Relays and motor sets
   // ****************************************
   localparam int RELAY_COUNT = 4;
   localparam int RELAY_FN_W = 4;
   localparam logic [3:0] RELAY_FN_MMC = 4'h5;
   localparam logic [3:0] RELAY_FN_RESET = 4'h0;
   localparam int MOTOR_PARAM_COUNT = 10;
   localparam int MOTOR_PARAM_W = 16;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      PPR_S_IDLE = 2'h0,
      PPR_S_TERMS = 2'h1,
      PPR_S_LIMIT = 2'h3
   } ppr_state_t;
   typedef enum logic [1:0] {
      PPR_SRC_CURRENT = 2'h0,
      PPR_SRC_V1 = 2'h1,
      PPR_SRC_V2 = 2'h2,
      PPR_SRC_PULSE = 2'h3
   } ppr_src_t;
   typedef enum logic {
      PPR_APP_NONE = 1'h0,
      PPR_APP_MMC = 1'h1
   } ppr_app_t;
endpackage : ppr_pkg

// file: verilog/ppr_motor_if.sv
// Interface carrying the two motor parameter sets and the chosen one.
`timescale 1ns/1ps
interface ppr_motor_if #(parameter int W = 160);
   logic select;
   logic [W-1:0] primary;
   logic [W-1:0] alternate;
   logic [W-1:0] active;
   logic active_sel;
   modport provider (input select, input primary, input alternate, output active, output active_sel);
   modport consumer (output select, output primary, output alternate, input active, input active_sel);
endinterface : ppr_motor_if

// file: verilog/ppr_motor_select.sv
// Selection between the first and second motor parameter sets.
`timescale 1ns/1ps
module ppr_motor_select #(
   parameter int W = 160
) (
   input wire logic clk,
   input wire logic sys_rst,
   ppr_motor_if.provider mif
);
   typedef struct packed {
      logic [W-1:0] active;
      logic sel;
   } ppr_msel_t;

   ppr_msel_t cur_reg;
   ppr_msel_t cur_next;

   always_comb begin
      cur_next = cur_reg;
      cur_next.sel = mif.select;
      // Only the listed set is switched; everything else stays common.
      cur_next.active = mif.select ? mif.alternate : mif.primary;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign mif.active = cur_reg.active;
   assign mif.active_sel = cur_reg.sel;

   a_second_set_used: assert property (@(posedge clk) disable iff (sys_rst)
      mif.select |=> (mif.active == $past(mif.alternate)) && mif.active_sel)
      else $error("Second parameter set not applied.");
   a_first_set_used: assert property (@(posedge clk) disable iff (sys_rst)
      !mif.select |=> (mif.active == $past(mif.primary)) && !mif.active_sel)
      else $error("Primary parameter set not applied.");
   c_set_switch: cover property (@(posedge clk) disable iff (sys_rst) $rose(mif.select));
endmodule : ppr_motor_select

// file: verilog/ppr_regulator.sv
// Process regulator: sampled PID loop producing the drive target frequency.
//
// Summary of operation
// - Recompute the output every ten milliseconds.
// - Regulator output becomes drive target frequency.
// - Error is set-point minus feedback, driven zero.
// - Proportional output equals gain times error.
// - Full error reaches full output after integral time.
// - Zero feedback at set-point means full error.
// - Derivative adds only to P, I or PI.
// - Clamp frequency between lower and upper limits.
// - Multiply output by the output scale.
// - Add set-point times feed-forward gain.
// - Set-point from normal or auxiliary source.
// - Feedback from current, two voltages or pulse.
// - Loop-bypass input forces zero, follows normal source.
// - Integrator-clear input zeroes the accumulator.
// - Second gain selectable, common gain scale.
// - Inversion setting negates the output.
// - Squaring option squares the feedback reading.
// - Multi-motor mode assigns four relays; none keeps.
// - Select input switches to alternate motor set.
// - Unlisted parameters stay shared between sets.
`timescale 1ns/1ps
module ppr_regulator #(
   parameter int SAMPLE_CYCLES = ppr_pkg::SAMPLE_CYCLES_DEFAULT,
   parameter int MP_W = ppr_pkg::MOTOR_PARAM_COUNT * ppr_pkg::MOTOR_PARAM_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic regulator_enable,
   input wire logic open_loop_input,
   input wire logic integrator_clear_input,
   input wire logic second_gain_select_input,
   input wire logic second_set_select_input,
   input wire logic aux_ref_enable,
   input wire logic [1:0] aux_ref_source,
   input wire logic [1:0] feedback_source,
   input wire logic feedback_squaring,
   input wire logic output_invert,
   input wire logic [15:0] normal_setpoint,
   input wire logic [15:0] normal_frequency,
   input wire logic [15:0] current_input,
   input wire logic [15:0] voltage_input_primary,
   input wire logic [15:0] voltage_input_secondary,
   input wire logic [15:0] pulse_input,
   input wire logic [15:0] proportional_gain,
   input wire logic [15:0] second_proportional_gain,
   input wire logic [15:0] gain_scale,
   input wire logic [15:0] integral_time,
   input wire logic [15:0] derivative_time,
   input wire logic [15:0] feed_forward_gain,
   input wire logic [15:0] output_scale,
   input wire logic [15:0] output_upper_limit,
   input wire logic [15:0] output_lower_limit,
   input wire logic [15:0] full_scale_frequency,
   input wire logic application_mode,
   input wire logic [3:0] relay_cfg_write,
   input wire logic [3:0] relay_cfg_code,
   input wire logic [MP_W-1:0] primary_motor_params,
   input wire logic [MP_W-1:0] alternate_motor_params,
   output logic [15:0] target_frequency,
   output logic signed [31:0] regulator_output,
   output logic regulating,
   output logic sample_pulse,
   output logic [15:0] aux_relay_function,
   output logic [MP_W-1:0] active_motor_params,
   output logic second_set_active
);
   localparam int CNT_W = $clog2(SAMPLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);
   localparam logic signed [63:0] FULL_S = 64'(ppr_pkg::PCT_FULL);
   localparam logic signed [63:0] UNITY_S = 64'(ppr_pkg::GAIN_UNITY);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      ppr_pkg::ppr_state_t st;
      logic [CNT_W-1:0] tick_cnt;
      logic sample_pulse;
      logic signed [47:0] acc;
      logic signed [47:0] acc_cand;
      logic signed [17:0] err_prev;
      logic signed [31:0] u;
      logic [15:0] target;
      logic signed [31:0] reg_out;
      logic regulating;
      logic [15:0] relay_fn;
      logic mode_prev;
   } ppr_state_vec_t;

   ppr_state_vec_t cur_reg;
   ppr_state_vec_t cur_next;

   function automatic logic [15:0] ppr_pick(input logic [1:0] src, input logic [15:0] i_in,
                                            input logic [15:0] v1, input logic [15:0] v2,
                                            input logic [15:0] pl);
      logic [15:0] r;
      r = i_in;
      unique case (ppr_pkg::ppr_src_t'(src))
         ppr_pkg::PPR_SRC_CURRENT: r = i_in;
         ppr_pkg::PPR_SRC_V1: r = v1;
         ppr_pkg::PPR_SRC_V2: r = v2;
         ppr_pkg::PPR_SRC_PULSE: r = pl;
      endcase
      return r;
   endfunction : ppr_pick

   // ****************************************
   // Motor parameter set selection
   // ****************************************
   ppr_motor_if #(.W(MP_W)) mif ();

   assign mif.select = second_set_select_input;
   assign mif.primary = primary_motor_params;
   assign mif.alternate = alternate_motor_params;

   ppr_motor_select #(.W(MP_W)) u_motor_select (
      .clk(clk),
      .sys_rst(sys_rst),
      .mif(mif)
   );

   // ****************************************
   // Loop computation
   // ****************************************
   logic signed [63:0] sp_w;
   logic signed [63:0] fb_w;
   logic signed [63:0] err_w;
   logic signed [63:0] kp_w;
   logic signed [63:0] p_w;
   logic signed [63:0] acc_w;
   logic signed [63:0] i_w;
   logic signed [63:0] d_w;
   logic signed [63:0] ff_w;
   logic signed [63:0] u_w;
   logic signed [63:0] f_w;
   logic clamped;

   always_comb begin
      cur_next = cur_reg;
      sp_w = '0;
      fb_w = '0;
      err_w = '0;
      kp_w = '0;
      p_w = '0;
      acc_w = '0;
      i_w = '0;
      d_w = '0;
      ff_w = '0;
      u_w = '0;
      f_w = '0;
      clamped = 1'b0;
      cur_next.sample_pulse = 1'b0;
      cur_next.mode_prev = application_mode;

      // Sample interval timer.
      if (cur_reg.tick_cnt == CNT_LAST) begin
         cur_next.tick_cnt = '0;
         cur_next.sample_pulse = 1'b1;
      end else begin
         cur_next.tick_cnt = cur_reg.tick_cnt + 1'b1;
      end

      sp_w = 64'(aux_ref_enable ? ppr_pick(aux_ref_source, current_input, voltage_input_primary,
                 voltage_input_secondary, pulse_input) : normal_setpoint);
      fb_w = 64'(ppr_pick(feedback_source, current_input, voltage_input_primary,
                 voltage_input_secondary, pulse_input));
      if (feedback_squaring) begin
         fb_w = fb_w * fb_w / FULL_S;
      end

      unique case (cur_reg.st)
         ppr_pkg::PPR_S_IDLE: begin
            if (cur_reg.sample_pulse) begin
               cur_next.st = ppr_pkg::PPR_S_TERMS;
            end
         end
         ppr_pkg::PPR_S_TERMS: begin
            // Error is relative to the set-point, so zero feedback is full error.
            err_w = sp_w - fb_w;
            if (sp_w != 0) begin
               err_w = err_w * FULL_S / sp_w;
            end
            if (err_w > FULL_S) begin
               err_w = FULL_S;
            end else if (err_w < -FULL_S) begin
               err_w = -FULL_S;
            end
            kp_w = 64'(second_gain_select_input ? second_proportional_gain : proportional_gain);
            kp_w = kp_w * 64'(gain_scale) / UNITY_S;
            p_w = err_w * kp_w / UNITY_S;
            // Unsigned settings are widened as signed so negative terms keep their sign.
            acc_w = 64'(cur_reg.acc) + err_w;
            if (integral_time != '0) begin
               i_w = acc_w / $signed(64'(64'(integral_time) * 64'(ppr_pkg::TI_SAMPLES_PER_UNIT)));
            end
            if (kp_w != 0 || integral_time != '0) begin
               d_w = (err_w - 64'(cur_reg.err_prev)) * $signed(64'(derivative_time))
                     / $signed(64'(ppr_pkg::TD_DIVISOR));
            end
            ff_w = sp_w * 64'(feed_forward_gain) / UNITY_S;
            u_w = (p_w + i_w + d_w + ff_w) * $signed(64'(output_scale)) / UNITY_S;
            if (output_invert) begin
               u_w = -u_w;
            end
            if (u_w > ppr_pkg::U_LIMIT) begin
               u_w = ppr_pkg::U_LIMIT;
            end else if (u_w < -ppr_pkg::U_LIMIT) begin
               u_w = -ppr_pkg::U_LIMIT;
            end
            cur_next.err_prev = err_w[17:0];
            cur_next.acc_cand = acc_w[47:0];
            cur_next.u = u_w[31:0];
            cur_next.st = ppr_pkg::PPR_S_LIMIT;
         end
         ppr_pkg::PPR_S_LIMIT: begin
            f_w = 64'(cur_reg.u) * $signed(64'(full_scale_frequency)) / FULL_S;
            if (f_w > $signed(64'(output_upper_limit))) begin
               f_w = 64'(output_upper_limit);
               clamped = 1'b1;
            end else if (f_w < $signed(64'(output_lower_limit))) begin
               f_w = 64'(output_lower_limit);
               clamped = 1'b1;
            end
            if (!clamped) begin
               cur_next.acc = cur_reg.acc_cand;
            end
            cur_next.target = f_w[15:0];
            cur_next.reg_out = cur_reg.u;
            cur_next.regulating = 1'b1;
            cur_next.st = ppr_pkg::PPR_S_IDLE;
         end
         default: begin
            cur_next.st = ppr_pkg::PPR_S_IDLE;
         end
      endcase

      // Disable and bypass override the loop; the drive follows its normal source.
      if (!regulator_enable) begin
         cur_next.st = ppr_pkg::PPR_S_IDLE;
         cur_next.acc = '0;
         cur_next.err_prev = '0;
         cur_next.target = normal_frequency;
         cur_next.reg_out = '0;
         cur_next.regulating = 1'b0;
      end else if (open_loop_input) begin
         cur_next.st = ppr_pkg::PPR_S_IDLE;
         cur_next.target = normal_frequency;
         cur_next.reg_out = '0;
         cur_next.regulating = 1'b0;
      end
      if (integrator_clear_input) begin
         cur_next.acc = '0;
         cur_next.acc_cand = '0;
      end

      // Relay function assignment.
      for (int k = 0; k < ppr_pkg::RELAY_COUNT; k++) begin
         if (relay_cfg_write[k]) begin
            cur_next.relay_fn[k*ppr_pkg::RELAY_FN_W +: ppr_pkg::RELAY_FN_W] = relay_cfg_code;
         end
      end
      if (application_mode == ppr_pkg::PPR_APP_MMC && cur_reg.mode_prev == ppr_pkg::PPR_APP_NONE) begin
         cur_next.relay_fn = {ppr_pkg::RELAY_COUNT{ppr_pkg::RELAY_FN_MMC}};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign target_frequency = cur_reg.target;
   assign regulator_output = cur_reg.reg_out;
   assign regulating = cur_reg.regulating;
   assign sample_pulse = cur_reg.sample_pulse;
   assign aux_relay_function = cur_reg.relay_fn;
   assign active_motor_params = mif.active;
   assign second_set_active = mif.active_sel;

   // ****************************************
   // Checks
   // ****************************************
   default clocking ppr_cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_sample_period: assert property (sample_pulse |-> $past(cur_reg.tick_cnt) == CNT_LAST)
      else $error("Sample pulse off its interval.");

   a_loop_start: assert property (sample_pulse && regulator_enable && !open_loop_input
      && cur_reg.st == ppr_pkg::PPR_S_IDLE ##1 regulator_enable && !open_loop_input
      ##1 regulator_enable && !open_loop_input |=> regulating)
      else $error("Sample did not update the output.");

   a_bypass_zero: assert property (regulator_enable && open_loop_input
      |=> regulator_output == 0 && !regulating && target_frequency == $past(normal_frequency))
      else $error("Bypass did not force the normal source.");

   a_clamp_range: assert property (cur_reg.st == ppr_pkg::PPR_S_LIMIT && regulator_enable
      && !open_loop_input && output_lower_limit <= output_upper_limit
      |=> target_frequency <= $past(output_upper_limit) && target_frequency >= $past(output_lower_limit))
      else $error("Target outside the limits.");

   a_iclear_zero: assert property (integrator_clear_input |=> cur_reg.acc == 0)
      else $error("Integrator not cleared.");

   a_windup_hold: assert property (cur_reg.st == ppr_pkg::PPR_S_LIMIT && regulator_enable
      && !integrator_clear_input
      && (64'(cur_reg.u) * $signed(64'(full_scale_frequency)) / FULL_S > $signed(64'(output_upper_limit)))
      |=> $stable(cur_reg.acc))
      else $error("Integrator moved while clamped.");
   a_windup_low: assert property (cur_reg.st == ppr_pkg::PPR_S_LIMIT && regulator_enable
      && !integrator_clear_input
      && (64'(cur_reg.u) * $signed(64'(full_scale_frequency)) / FULL_S < $signed(64'(output_lower_limit)))
      |=> $stable(cur_reg.acc))
      else $error("Integrator moved while clamped low.");

   a_relay_assign: assert property ($rose(application_mode) && cur_reg.mode_prev == 1'b0
      |=> aux_relay_function == {ppr_pkg::RELAY_COUNT{ppr_pkg::RELAY_FN_MMC}})
      else $error("Relays not assigned on mode entry.");
   a_relay_keep: assert property ($fell(application_mode) && relay_cfg_write == '0
      |=> $stable(aux_relay_function))
      else $error("Relays changed on leaving mode.");

   c_clamped_upper: cover property (cur_reg.st == ppr_pkg::PPR_S_LIMIT ##1 target_frequency == output_upper_limit);
   c_clamped_lower: cover property (cur_reg.st == ppr_pkg::PPR_S_LIMIT ##1 target_frequency == output_lower_limit);
   c_bypass: cover property (regulating ##1 open_loop_input);
   c_mmc_entry: cover property ($rose(application_mode));
endmodule : ppr_regulator

// file: testbench/ppr_field_model.sv
// Field-side model: process sensor readings and the motor-swap terminal.
`timescale 1ns/1ps
module ppr_field_model (
   input wire logic clk,
   input wire logic load,
   input wire logic [1:0] src,
   input wire logic [15:0] level,
   input wire logic swap_req,
   input wire logic motor_running,
   output logic [15:0] current_input,
   output logic [15:0] voltage_input_primary,
   output logic [15:0] voltage_input_secondary,
   output logic [15:0] pulse_input,
   output logic set_select
);
   logic [15:0] rd [4];
   initial begin
      for (int i = 0; i < 4; i++) begin
         rd[i] = 16'h0000;
      end
      set_select = 1'b0;
   end
   always @(posedge clk) begin
      if (load) begin
         rd[src] <= level;
      end
      // The motor wiring is only exchanged while the motor stands still.
      if (!motor_running) begin
         set_select <= swap_req;
      end
   end
   assign current_input = rd[0];
   assign voltage_input_primary = rd[1];
   assign voltage_input_secondary = rd[2];
   assign pulse_input = rd[3];
endmodule : ppr_field_model

// file: testbench/test_ppr_regulator.sv
// Self-checking bench for the process regulator.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
   $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module test_ppr_regulator;
   localparam int SC = 50;
   localparam int MPW = ppr_pkg::MOTOR_PARAM_COUNT * ppr_pkg::MOTOR_PARAM_W;
   logic clk, sys_rst, regulator_enable, open_loop_input, integrator_clear_input, second_gain_select_input;
   logic second_set_select_input, aux_ref_enable, feedback_squaring, output_invert, application_mode;
   logic regulating, sample_pulse, second_set_active, load, swap_req, motor_running;
   logic [1:0] aux_ref_source, feedback_source, src;
   logic [3:0] relay_cfg_write, relay_cfg_code;
   logic [15:0] normal_setpoint, normal_frequency, current_input, voltage_input_primary, voltage_input_secondary;
   logic [15:0] pulse_input, proportional_gain, second_proportional_gain, gain_scale, integral_time;
   logic [15:0] derivative_time, feed_forward_gain, output_scale, output_upper_limit, output_lower_limit;
   logic [15:0] full_scale_frequency, target_frequency, aux_relay_function, level;
   logic signed [31:0] regulator_output;
   logic [MPW-1:0] primary_motor_params, alternate_motor_params, active_motor_params;
   int err_total, check_count, n;

   ppr_regulator #(.SAMPLE_CYCLES(SC), .MP_W(MPW)) ppr_regulator_i (.clk(clk), .sys_rst(sys_rst),
      .regulator_enable(regulator_enable), .open_loop_input(open_loop_input),
      .integrator_clear_input(integrator_clear_input), .second_gain_select_input(second_gain_select_input),
      .second_set_select_input(second_set_select_input), .aux_ref_enable(aux_ref_enable),
      .aux_ref_source(aux_ref_source), .feedback_source(feedback_source), .feedback_squaring(feedback_squaring),
      .output_invert(output_invert), .normal_setpoint(normal_setpoint), .normal_frequency(normal_frequency),
      .current_input(current_input), .voltage_input_primary(voltage_input_primary),
      .voltage_input_secondary(voltage_input_secondary), .pulse_input(pulse_input),
      .proportional_gain(proportional_gain), .second_proportional_gain(second_proportional_gain),
      .gain_scale(gain_scale), .integral_time(integral_time), .derivative_time(derivative_time),
      .feed_forward_gain(feed_forward_gain), .output_scale(output_scale), .output_upper_limit(output_upper_limit),
      .output_lower_limit(output_lower_limit), .full_scale_frequency(full_scale_frequency),
      .application_mode(application_mode), .relay_cfg_write(relay_cfg_write), .relay_cfg_code(relay_cfg_code),
      .primary_motor_params(primary_motor_params), .alternate_motor_params(alternate_motor_params),
      .target_frequency(target_frequency), .regulator_output(regulator_output), .regulating(regulating),
      .sample_pulse(sample_pulse), .aux_relay_function(aux_relay_function),
      .active_motor_params(active_motor_params), .second_set_active(second_set_active));

   ppr_field_model ppr_field_model_i (.clk(clk), .load(load), .src(src), .level(level), .swap_req(swap_req),
      .motor_running(motor_running), .current_input(current_input), .voltage_input_primary(voltage_input_primary),
      .voltage_input_secondary(voltage_input_secondary), .pulse_input(pulse_input),
      .set_select(second_set_select_input));

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic set_fb(input logic [1:0] s, input logic [15:0] v);
      src = s;
      level = v;
      load = 1'b1;
      @(negedge clk);
      load = 1'b0;
      @(negedge clk);
   endtask : set_fb

   task automatic wait_pulse;
      n = 0;
      @(negedge clk);
      while (sample_pulse !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      `CHK("sample_pulse", 1'b1, sample_pulse)
   endtask : wait_pulse

   // Each new result lands three edges after the sample pulse; one spare edge is allowed.
   task automatic sample_chk(input logic signed [31:0] eu, input logic [15:0] ef);
      wait_pulse;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK("regulator_output", eu, regulator_output)
      `CHK("target_frequency", ef, target_frequency)
      `CHK("regulating", 1'b1, regulating)
   endtask : sample_chk

   // ****************************************
   // Clock, reset and tests
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      #100000;
      err_total++;
      $display("unexpected watchdog exp done got hang");
      stop_test;
   end

   initial begin
      {regulator_enable, open_loop_input, integrator_clear_input, second_gain_select_input} = 4'h0;
      {aux_ref_enable, feedback_squaring, output_invert, application_mode, load} = 5'h00;
      {swap_req, motor_running, relay_cfg_write, relay_cfg_code} = 10'h000;
      {aux_ref_source, feedback_source, src, level} = 22'h000000;
      sys_rst = 1'b1;
      normal_setpoint = 16'h2710;
      normal_frequency = 16'h04d2;
      proportional_gain = 16'h01f4;
      second_proportional_gain = 16'h00fa;
      gain_scale = 16'h03e8;
      {integral_time, derivative_time, feed_forward_gain, output_lower_limit} = 64'h0;
      output_scale = 16'h03e8;
      output_upper_limit = 16'h1770;
      full_scale_frequency = 16'h1770;
      primary_motor_params = {10{16'h1111}};
      alternate_motor_params = {10{16'h2222}};
      repeat (4) @(posedge clk);
      `CHK("target_frequency", 16'h0000, target_frequency)
      @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("target_frequency", 16'h04d2, target_frequency)
      regulator_enable = 1'b1;
      wait_pulse;
      @(negedge clk);
      `CHK("pulse width", 1'b0, sample_pulse)
      wait_pulse;
      `CHK("sample spacing", SC - 2, n)
      sample_chk(32'h00001388, 16'h0bb8);
      open_loop_input = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("target_frequency", 16'h04d2, target_frequency)
      `CHK("regulator_output", 32'h00000000, regulator_output)
      `CHK("regulating", 1'b0, regulating)
      open_loop_input = 1'b0;
      sample_chk(32'h00001388, 16'h0bb8);
      $display("test basic done");
      proportional_gain = 16'h03e8;
      for (int s = 0; s < 4; s++) begin
         feedback_source = 2'(s);
         set_fb(2'(s), 16'h1388);
         sample_chk(32'h00001388, 16'h0bb8);
         set_fb(2'(s), 16'h0000);
      end
      feedback_source = 2'h0;
      set_fb(2'h0, 16'h1388);
      feedback_squaring = 1'b1;
      sample_chk(32'h00001d4c, 16'h1194);
      feedback_squaring = 1'b0;
      output_invert = 1'b1;
      output_lower_limit = 16'h012c;
      sample_chk(32'hffffec78, 16'h012c);
      output_invert = 1'b0;
      output_lower_limit = 16'h0000;
      proportional_gain = 16'h07d0;
      set_fb(2'h0, 16'h0000);
      sample_chk(32'h00004e20, 16'h1770);
      proportional_gain = 16'h03e8;
      output_scale = 16'h01f4;
      sample_chk(32'h00001388, 16'h0bb8);
      output_scale = 16'h03e8;
      second_gain_select_input = 1'b1;
      gain_scale = 16'h07d0;
      sample_chk(32'h00001388, 16'h0bb8);
      second_gain_select_input = 1'b0;
      gain_scale = 16'h03e8;
      $display("test options done");
      set_fb(2'h0, 16'h0fa0);
      set_fb(2'h1, 16'h1f40);
      aux_ref_enable = 1'b1;
      aux_ref_source = 2'h1;
      sample_chk(32'h00001388, 16'h0bb8);
      aux_ref_enable = 1'b0;
      sample_chk(32'h00001770, 16'h0e10);
      proportional_gain = 16'h0000;
      feed_forward_gain = 16'h01f4;
      set_fb(2'h0, 16'h2710);
      sample_chk(32'h00001388, 16'h0bb8);
      feed_forward_gain = 16'h0000;
      proportional_gain = 16'h03e8;
      derivative_time = 16'h0064;
      sample_chk(32'h00000000, 16'h0000);
      set_fb(2'h0, 16'h1388);
      sample_chk(32'h00002710, 16'h1770);
      proportional_gain = 16'h0000;
      set_fb(2'h0, 16'h0000);
      sample_chk(32'h00000000, 16'h0000);
      derivative_time = 16'h0000;
      $display("test reference done");
      integral_time = 16'h0001;
      regulator_enable = 1'b0;
      @(negedge clk);
      regulator_enable = 1'b1;
      sample_chk(32'h000003e8, 16'h0258);
      sample_chk(32'h000007d0, 16'h04b0);
      integrator_clear_input = 1'b1;
      @(negedge clk);
      integrator_clear_input = 1'b0;
      sample_chk(32'h000003e8, 16'h0258);
      output_upper_limit = 16'h0384;
      sample_chk(32'h000007d0, 16'h0384);
      sample_chk(32'h000007d0, 16'h0384);
      $display("test integral done");
      relay_cfg_code = 4'h3;
      relay_cfg_write = 4'h4;
      @(negedge clk);
      relay_cfg_write = 4'h0;
      @(negedge clk);
      `CHK("aux_relay_function", 16'h0300, aux_relay_function)
      application_mode = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("aux_relay_function", 16'h5555, aux_relay_function)
      application_mode = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("aux_relay_function", 16'h5555, aux_relay_function)
      relay_cfg_code = 4'h1;
      relay_cfg_write = 4'h1;
      @(negedge clk);
      relay_cfg_write = 4'h0;
      @(negedge clk);
      `CHK("aux_relay_function", 16'h5551, aux_relay_function)
      `CHK("active_motor_params", {10{16'h1111}}, active_motor_params)
      motor_running = 1'b1;
      swap_req = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("second_set_active", 1'b0, second_set_active)
      motor_running = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("active_motor_params", {10{16'h2222}}, active_motor_params)
      `CHK("second_set_active", 1'b1, second_set_active)
      $display("test relays and motor sets done");
      stop_test;
   end
endmodule : test_ppr_regulator
